// *** core/pmtr_pkg.sv ***
package pmtr_pkg;
    localparam int          PMTR_ADDR_W    = 12;
    localparam int          PMTR_WORD_W    = 16;
    localparam int          PMTR_DEPTH     = 4096;
    localparam int          PMTR_DATA_W    = 8;
    localparam int          PMTR_SECT_W    = 2;
    localparam int          PMTR_RAMA_W    = 8;
    localparam logic [11:0] PMTR_RESET_VEC = 12'h000;
    localparam logic [7:0]  PMTR_PTR_RST   = 8'h00;
    localparam logic [7:0]  PMTR_TBH_RST   = 8'h00;
    localparam logic [1:0]  PMTR_SECT_STD  = 2'h0;
    localparam int          PMTR_PROG_CNT_W = 4;
    localparam int          PMTR_PROG_BITS = 16;
    localparam int          PMTR_ADDR_BITS = 12;

    typedef enum logic [2:0] {
        PMTR_OP_NOP,
        PMTR_OP_TABRD,
        PMTR_OP_TABRD_EXT,
        PMTR_OP_ADD,
        PMTR_OP_SUB,
        PMTR_OP_AND,
        PMTR_OP_OR,
        PMTR_OP_XOR
    } pmtr_op_t;

    typedef enum {
        PMTR_ST_IDLE,
        PMTR_ST_TABLE2
    } pmtr_state_t;

    typedef enum {
        PMTR_PG_ADDR,
        PMTR_PG_WDATA,
        PMTR_PG_RDATA
    } pmtr_pgst_t;
endpackage

// *** core/pmtr_program_memory.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmtr_program_memory (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Core instruction request
    input  wire pmtr_pkg::pmtr_op_t     op,
    input  wire logic                   opValid,
    input  wire logic                   pcLoad,
    input  wire logic [11:0]            pcLoadValue,
    input  wire logic [1:0]             destSector,
    input  wire logic [7:0]             destAddr,
    input  wire logic [7:0]             aluA,
    input  wire logic [7:0]             aluB,
    input  wire logic                   aluCarryIn,
    // Pointer and latch access
    input  wire logic                   tablePtrLowWr,
    input  wire logic                   tablePtrHighWr,
    input  wire logic                   tableHighByteLatchWr,
    input  wire logic [7:0]             wrData,
    output logic [7:0]                  tablePtrLow,
    output logic [7:0]                  tablePtrHigh,
    output logic [7:0]                  table_high_byte_latch,
    // Fetch side
    output logic [11:0]                 pc,
    output logic [15:0]                 instrWord,
    output logic                        busy,
    // Data memory write-back
    output logic                        dmWrEn,
    output logic [1:0]                  dmWrSector,
    output logic [7:0]                  dmWrAddr,
    output logic [7:0]                  dmWrData,
    output logic                        tableSectorErr,
    // Status flags
    output logic                        flagCarry,
    output logic                        flagZero,
    output logic                        flagOverflow,
    output logic                        flagAuxCarry,
    // Serial programming pins
    input  wire logic                   prog_serial_clock_line,
    input  wire logic                   prog_serial_data_line_in,
    output logic                        prog_serial_data_line_out,
    output logic                        prog_serial_data_line_oe,
    input  wire logic                   progMode
);
    logic [15:0] mem [0:pmtr_pkg::PMTR_DEPTH-1];
    pmtr_pkg::pmtr_state_t state;
    logic [11:0] tableAddr;
    logic [1:0]  pendSector;
    logic [7:0]  pendAddr;
    logic        stdOp;
    logic        tableOp;
    logic        sectorOk;
    logic [15:0] tableWord;
    logic [8:0]  aluSum;
    logic [7:0]  aluRes;
    logic [4:0]  auxSum;

    assign tableAddr = {tablePtrHigh[3:0], tablePtrLow};
    assign stdOp     = (op == pmtr_pkg::PMTR_OP_TABRD);
    assign tableOp   = opValid && (stdOp || op == pmtr_pkg::PMTR_OP_TABRD_EXT);
    assign sectorOk  = !stdOp || (destSector == pmtr_pkg::PMTR_SECT_STD);
    assign busy      = (state == pmtr_pkg::PMTR_ST_TABLE2);
    assign tableWord = mem[tableAddr];

    // Program counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc <= pmtr_pkg::PMTR_RESET_VEC;
        end else if (progMode) begin
            pc <= pmtr_pkg::PMTR_RESET_VEC;
        end else if (pcLoad) begin
            pc <= pcLoadValue;
        end else if (!(tableOp && state == pmtr_pkg::PMTR_ST_IDLE)) begin
            pc <= pc + 12'h001;
        end
    end

    // Instruction fetch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instrWord <= 16'h0000;
        end else begin
            instrWord <= mem[pc];
        end
    end

    // Two-cycle table sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= pmtr_pkg::PMTR_ST_IDLE;
            pendSector <= 2'h0;
            pendAddr   <= 8'h00;
        end else begin
            case (state)
                pmtr_pkg::PMTR_ST_IDLE: begin
                    if (tableOp) begin
                        state      <= pmtr_pkg::PMTR_ST_TABLE2;
                        pendSector <= destSector;
                        pendAddr   <= destAddr;
                    end
                end
                pmtr_pkg::PMTR_ST_TABLE2: begin
                    state <= pmtr_pkg::PMTR_ST_IDLE;
                end
                default: begin
                    state <= pmtr_pkg::PMTR_ST_IDLE;
                end
            endcase
        end
    end

    // Pointer registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tablePtrLow  <= pmtr_pkg::PMTR_PTR_RST;
            tablePtrHigh <= pmtr_pkg::PMTR_PTR_RST;
        end else begin
            if (tablePtrLowWr) begin
                tablePtrLow <= wrData;
            end
            if (tablePtrHighWr) begin
                tablePtrHigh <= wrData;
            end
        end
    end

    // High byte latch; table load wins over a software write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            table_high_byte_latch <= pmtr_pkg::PMTR_TBH_RST;
        end else if (tableOp && state == pmtr_pkg::PMTR_ST_IDLE) begin
            table_high_byte_latch <= tableWord[15:8];
        end else if (tableHighByteLatchWr) begin
            table_high_byte_latch <= wrData;
        end
    end

    // Data memory write-back
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dmWrEn         <= 1'b0;
            dmWrSector     <= 2'h0;
            dmWrAddr       <= 8'h00;
            dmWrData       <= 8'h00;
            tableSectorErr <= 1'b0;
        end else begin
            dmWrEn         <= 1'b0;
            tableSectorErr <= 1'b0;
            if (tableOp && state == pmtr_pkg::PMTR_ST_IDLE) begin
                dmWrEn         <= sectorOk;
                tableSectorErr <= !sectorOk;
                dmWrSector     <= destSector;
                dmWrAddr       <= destAddr;
                dmWrData       <= tableWord[7:0];
            end else if (opValid && op >= pmtr_pkg::PMTR_OP_ADD) begin
                dmWrEn     <= 1'b1;
                dmWrSector <= destSector;
                dmWrAddr   <= destAddr;
                dmWrData   <= aluRes;
            end
        end
    end

    // ALU
    always_comb begin
        aluSum = 9'h000;
        auxSum = 5'h00;
        aluRes = 8'h00;
        case (op)
            pmtr_pkg::PMTR_OP_ADD: begin
                aluSum = {1'b0, aluA} + {1'b0, aluB} + {8'h00, aluCarryIn};
                auxSum = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCarryIn};
                aluRes = aluSum[7:0];
            end
            pmtr_pkg::PMTR_OP_SUB: begin
                aluSum = {1'b0, aluA} + {1'b0, ~aluB} + {8'h00, aluCarryIn};
                auxSum = {1'b0, aluA[3:0]} + {1'b0, ~aluB[3:0]} + {4'h0, aluCarryIn};
                aluRes = aluSum[7:0];
            end
            pmtr_pkg::PMTR_OP_AND: aluRes = aluA & aluB;
            pmtr_pkg::PMTR_OP_OR:  aluRes = aluA | aluB;
            pmtr_pkg::PMTR_OP_XOR: aluRes = aluA ^ aluB;
            default: aluRes = 8'h00;
        endcase
    end

    // Status flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flagCarry    <= 1'b0;
            flagZero     <= 1'b0;
            flagOverflow <= 1'b0;
            flagAuxCarry <= 1'b0;
        end else if (opValid && op >= pmtr_pkg::PMTR_OP_ADD) begin
            flagZero <= (aluRes == 8'h00);
            if (op == pmtr_pkg::PMTR_OP_ADD || op == pmtr_pkg::PMTR_OP_SUB) begin
                flagCarry    <= aluSum[8];
                flagAuxCarry <= auxSum[4];
                flagOverflow <= (aluA[7] == (op == pmtr_pkg::PMTR_OP_SUB ? ~aluB[7] : aluB[7]))
                                && (aluRes[7] != aluA[7]);
            end
        end
    end

    // Serial programming: pins synchronised, then edge detected
    logic [2:0]  ckSync;
    logic [1:0]  daSync;
    logic        ckRise;
    pmtr_pkg::pmtr_pgst_t pgState;
    logic [3:0]  bitCnt;
    logic [11:0] pgAddr;
    logic [15:0] pgShift;

    assign ckRise = ckSync[1] && !ckSync[2];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ckSync <= 3'h0;
            daSync <= 2'h0;
        end else begin
            ckSync <= {ckSync[1:0], prog_serial_clock_line};
            daSync <= {daSync[0], prog_serial_data_line_in};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pgState <= pmtr_pkg::PMTR_PG_ADDR;
            bitCnt  <= 4'h0;
            pgAddr  <= 12'h000;
            pgShift <= 16'h0000;
        end else if (!progMode) begin
            pgState <= pmtr_pkg::PMTR_PG_ADDR;
            bitCnt  <= 4'h0;
        end else if (ckRise) begin
            bitCnt <= bitCnt + 4'h1;
            case (pgState)
                pmtr_pkg::PMTR_PG_ADDR: begin
                    pgAddr <= {pgAddr[10:0], daSync[1]};
                    if (bitCnt == 4'(pmtr_pkg::PMTR_ADDR_BITS - 1)) begin
                        bitCnt  <= 4'h0;
                        pgState <= daSync[1] ? pmtr_pkg::PMTR_PG_RDATA : pmtr_pkg::PMTR_PG_WDATA;
                        pgShift <= mem[{pgAddr[10:0], daSync[1]}];
                    end
                end
                pmtr_pkg::PMTR_PG_WDATA: begin
                    pgShift <= {pgShift[14:0], daSync[1]};
                    if (bitCnt == 4'(pmtr_pkg::PMTR_PROG_BITS - 1)) begin
                        pgAddr <= pgAddr + 12'h001;
                    end
                end
                pmtr_pkg::PMTR_PG_RDATA: begin
                    pgShift <= {pgShift[14:0], 1'b0};
                    if (bitCnt == 4'(pmtr_pkg::PMTR_PROG_BITS - 1)) begin
                        pgAddr  <= pgAddr + 12'h001;
                        pgShift <= mem[pgAddr + 12'h001];
                    end
                end
                default: pgState <= pmtr_pkg::PMTR_PG_ADDR;
            endcase
        end
    end

    // Store write from programming port
    always_ff @(posedge clk) begin
        if (progMode && ckRise && pgState == pmtr_pkg::PMTR_PG_WDATA
            && bitCnt == 4'(pmtr_pkg::PMTR_PROG_BITS - 1)) begin
            mem[pgAddr] <= {pgShift[14:0], daSync[1]};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_serial_data_line_out <= 1'b0;
            prog_serial_data_line_oe  <= 1'b0;
        end else begin
            prog_serial_data_line_out <= pgShift[15];
            prog_serial_data_line_oe  <= progMode && pgState == pmtr_pkg::PMTR_PG_RDATA;
        end
    end
endmodule
`default_nettype wire

// *** bench/pmtr_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmtr_chk (
    // Clock, reset and requests
    input wire logic               clk,
    input wire logic               rst_b,
    input wire pmtr_pkg::pmtr_op_t op,
    input wire logic               opValid,
    input wire logic               pcLoad,
    input wire logic [11:0]        pcLoadValue,
    input wire logic [1:0]         destSector,
    input wire logic [7:0]         destAddr,
    input wire logic               tablePtrLowWr,
    input wire logic               tableHighByteLatchWr,
    input wire logic [7:0]         wrData,
    input wire logic               progMode,
    // Design outputs
    input wire logic [7:0]         tablePtrLow,
    input wire logic [7:0]         table_high_byte_latch,
    input wire logic [11:0]        pc,
    input wire logic               busy,
    input wire logic               dmWrEn,
    input wire logic [1:0]         dmWrSector,
    input wire logic [7:0]         dmWrAddr,
    input wire logic [7:0]         dmWrData,
    input wire logic               tableSectorErr,
    input wire logic               flagZero
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic isTab = op == pmtr_pkg::PMTR_OP_TABRD || op == pmtr_pkg::PMTR_OP_TABRD_EXT;
    wire logic tabGo = opValid && !busy && isTab;

    rst_vec_a: assert property ($rose(rst_b) |-> pc == 12'h000) else $error("pc not at zero after reset");
    pc_jump_a: assert property (pcLoad |=> pc == $past(pcLoadValue)) else $error("pc jump lost");
    pc_step_a: assert property (!pcLoad && !progMode && !busy && !tabGo |=> pc == $past(pc) + 12'h001)
        else $error("pc did not step");
    tab_ext_a: assert property (tabGo && op == pmtr_pkg::PMTR_OP_TABRD_EXT |=>
        dmWrEn && busy && dmWrSector == $past(destSector) && dmWrAddr == $past(destAddr) ##1 !busy)
        else $error("extended table read wrong");
    std_refuse_a: assert property (tabGo && op == pmtr_pkg::PMTR_OP_TABRD && destSector != 2'h0
        |=> tableSectorErr && !dmWrEn) else $error("standard read left sector 0");
    std_ok_a: assert property (tabGo && op == pmtr_pkg::PMTR_OP_TABRD && destSector == 2'h0
        |=> dmWrEn && dmWrSector == 2'h0 && !tableSectorErr) else $error("standard read not written");
    latch_sw_a: assert property (tableHighByteLatchWr && !tabGo && !busy
        |=> table_high_byte_latch == $past(wrData)) else $error("latch write lost");
    ptr_low_a: assert property (tablePtrLowWr |=> tablePtrLow == $past(wrData))
        else $error("pointer write lost");
    alu_zero_a: assert property (opValid && !busy && op >= pmtr_pkg::PMTR_OP_ADD
        |=> dmWrEn && flagZero == (dmWrData == 8'h00)) else $error("alu result or zero flag wrong");

    cover property (tabGo ##2 tabGo);
    cover property (tableSectorErr);
    cover property (dmWrEn && flagZero);
endmodule
bind pmtr_program_memory pmtr_chk u_chk (.clk, .rst_b, .op, .opValid, .pcLoad, .pcLoadValue, .destSector,
    .destAddr, .tablePtrLowWr, .tableHighByteLatchWr, .wrData, .progMode, .tablePtrLow, .table_high_byte_latch,
    .pc, .busy, .dmWrEn, .dmWrSector, .dmWrAddr, .dmWrData, .tableSectorErr, .flagZero);
`default_nettype wire

// *** bench/pmtr_dmem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmtr_dmem_model (
    // Write-back from the core
    input wire logic       clk,
    input wire logic       dmWrEn,
    input wire logic [1:0] dmWrSector,
    input wire logic [7:0] dmWrAddr,
    input wire logic [7:0] dmWrData
);
    logic [7:0] mem [0:1023];
    always_ff @(posedge clk) begin
        if (dmWrEn) begin
            mem[{dmWrSector, dmWrAddr}] <= dmWrData;
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    pmtr_pkg::pmtr_op_t op = pmtr_pkg::PMTR_OP_NOP;
    pmtr_pkg::pmtr_op_t o;
    logic               opValid = 0, pcLoad = 0, aluCarryIn = 0, progMode = 0;
    logic               tablePtrLowWr = 0, tablePtrHighWr = 0, tableHighByteLatchWr = 0;
    logic               prog_serial_clock_line = 0, prog_serial_data_line_in = 0;
    logic [11:0]        pcLoadValue = 12'h000, pc;
    logic [1:0]         destSector = 2'h0, dmWrSector;
    logic [7:0]         destAddr = 8'h00, aluA = 8'h00, aluB = 8'h00, wrData = 8'h00, a, b, r;
    logic [7:0]         tablePtrLow, tablePtrHigh, table_high_byte_latch, dmWrAddr, dmWrData;
    logic [15:0]        instrWord;
    logic               busy, dmWrEn, tableSectorErr, flagCarry, flagZero, flagOverflow, flagAuxCarry;
    logic               prog_serial_data_line_out, prog_serial_data_line_oe;
    logic [31:0]        seed = 32'h8076;
    logic [28:0]        expQ [$];
    logic [7:0]         expLat = 8'h00;
    logic               expC = 0, expZ = 0, expV = 0, expA = 0;
    int                 num_errors = 0, checks_done = 0;

    pmtr_program_memory DUT (.clk, .rst_b, .op, .opValid, .pcLoad, .pcLoadValue, .destSector, .destAddr, .aluA,
        .aluB, .aluCarryIn, .tablePtrLowWr, .tablePtrHighWr, .tableHighByteLatchWr, .wrData, .tablePtrLow,
        .tablePtrHigh, .table_high_byte_latch, .pc, .instrWord, .busy, .dmWrEn, .dmWrSector, .dmWrAddr, .dmWrData,
        .tableSectorErr, .flagCarry, .flagZero, .flagOverflow, .flagAuxCarry, .prog_serial_clock_line,
        .prog_serial_data_line_in, .prog_serial_data_line_out, .prog_serial_data_line_oe, .progMode);
    pmtr_dmem_model u_dmem (.clk, .dmWrEn, .dmWrSector, .dmWrAddr, .dmWrData);

    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic chk(input logic [28:0] e, input logic [28:0] g);
        checks_done++;
        if (e !== g) begin
            num_errors++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Serial frame bits, clock line low between frames
    task automatic pword(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            prog_serial_data_line_in = w[i];
            tick(4);
            prog_serial_clock_line = 1'b1;
            tick(4);
            prog_serial_clock_line = 1'b0;
        end
    endtask

    // Read frame: the driven bit is sampled before each clock rise
    task automatic pread(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            tick(4);
            chk({27'h0, 1'b1, w[i]}, {27'h0, prog_serial_data_line_oe, prog_serial_data_line_out});
            prog_serial_clock_line = 1'b1;
            tick(4);
            prog_serial_clock_line = 1'b0;
        end
    endtask

    task automatic wr3(input logic [2:0] sel, input logic [7:0] v);
        {tableHighByteLatchWr, tablePtrHighWr, tablePtrLowWr} = sel;
        wrData = v;
        tick(1);
        {tableHighByteLatchWr, tablePtrHighWr, tablePtrLowWr} = 3'h0;
        tick(1);
    endtask

    task automatic note(input logic [7:0] l, input logic [1:0] s, input logic [7:0] d, input logic [7:0] v);
        expQ.push_back({1'b0, l, expC, expZ, s, d, v});
    endtask

    task automatic doOp(input pmtr_pkg::pmtr_op_t p, input logic [1:0] s, input logic [7:0] d,
                        input logic [7:0] x, input logic [7:0] y);
        op = p;
        opValid = 1'b1;
        destSector = s;
        destAddr = d;
        aluA = x;
        aluB = y;
        aluCarryIn = p == pmtr_pkg::PMTR_OP_SUB;
        tick(1);
        if (p == pmtr_pkg::PMTR_OP_TABRD || p == pmtr_pkg::PMTR_OP_TABRD_EXT) begin
            tick(1);
        end
    endtask

    always @(posedge clk) begin
        #1;
        if (dmWrEn === 1'b1 || tableSectorErr === 1'b1) begin
            chk(expQ.pop_front(), tableSectorErr ? {1'b1, 28'h0} :
                {1'b0, table_high_byte_latch, flagCarry, flagZero, dmWrSector, dmWrAddr, dmWrData});
        end
    end

    initial begin
        #500000;
        num_errors++;
        summarize;
    end

    initial begin
        tick(3);
        rst_b = 1'b1;
        progMode = 1'b1;
        tick(2);
        pword(16'h0F06, 12);
        pword(16'h1A5C, 16);
        pword(16'hC3E1, 16);
        progMode = 1'b0;
        tick(1);
        progMode = 1'b1;
        pword(16'h0F07, 12);
        pread(16'hC3E1);
        prog_serial_data_line_in = ~prog_serial_data_line_in;
        tick(8);
        progMode = 1'b0;
        pcLoad = 1'b1;
        pcLoadValue = 12'hF06;
        tick(1);
        pcLoad = 1'b0;
        tick(1);
        chk({13'h0, 16'h1A5C}, {13'h0, instrWord});
        tick(1);
        chk({13'h0, 16'hC3E1}, {13'h0, instrWord});
        wr3(3'h1, 8'h06);
        wr3(3'h2, 8'hAF);
        chk({21'h0, 8'hAF}, {21'h0, tablePtrHigh});
        note(8'h1A, 2'h2, 8'h33, 8'h5C);
        doOp(pmtr_pkg::PMTR_OP_TABRD_EXT, 2'h2, 8'h33, 8'h00, 8'h00);
        opValid = 1'b0;
        wr3(3'h1, 8'h07);
        note(8'hC3, 2'h0, 8'h44, 8'hE1);
        doOp(pmtr_pkg::PMTR_OP_TABRD, 2'h0, 8'h44, 8'h00, 8'h00);
        expQ.push_back({1'b1, 28'h0});
        doOp(pmtr_pkg::PMTR_OP_TABRD, 2'h1, 8'h55, 8'h00, 8'h00);
        opValid = 1'b0;
        tick(2);
        chk({21'h0, 8'h5C}, {21'h0, u_dmem.mem[{2'h2, 8'h33}]});
        wr3(3'h4, 8'h5A);
        expLat = 8'h5A;
        chk({21'h0, expLat}, {21'h0, table_high_byte_latch});
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            o = pmtr_pkg::pmtr_op_t'(3'(3 + seed[2:0] % 5));
            a = seed[15:8];
            b = seed[31:30] == 2'h0 ? a : seed[23:16];
            case (o)
                pmtr_pkg::PMTR_OP_ADD: begin
                    {expC, r} = {1'b0, a} + {1'b0, b};
                    expA = 5'(a[3:0]) + 5'(b[3:0]) > 5'h0F;
                    expV = a[7] == b[7] && r[7] != a[7];
                end
                pmtr_pkg::PMTR_OP_SUB: begin
                    {expC, r} = {a >= b, a - b};
                    expA = a[3:0] >= b[3:0];
                    expV = a[7] != b[7] && r[7] != a[7];
                end
                pmtr_pkg::PMTR_OP_AND: r = a & b;
                pmtr_pkg::PMTR_OP_OR: r = a | b;
                default: r = a ^ b;
            endcase
            expZ = r == 8'h00;
            note(expLat, seed[25:24], seed[7:0], r);
            doOp(o, seed[25:24], seed[7:0], a, b);
            chk({27'h0, expV, expA}, {27'h0, flagOverflow, flagAuxCarry});
        end
        opValid = 1'b0;
        tick(3);
        chk(29'h0, 29'(expQ.size()));
        summarize;
    end
endmodule
`default_nettype wire
